// *** include/frc_pkg.sv ***
// Package for the frequency reference combiner and run command decoder.
// Assumes one 20 MHz clock domain and a synchronous active-low reset.
package frc_pkg;
  localparam int FREQ_W = 16;
  localparam int PCT_W = 8;
  localparam int TERM_N = 5;
  localparam logic [7:0] PCT_MAX = 8'h96;
  localparam logic [7:0] PCT_FULL = 8'h64;
  localparam logic [7:0] PCT_RESET = 8'h00;
  localparam logic [4:0] POL_RESET = 5'h00;
  localparam int TERM_FWD_POS = 0;
  localparam int TERM_REV_POS = 1;
  localparam int TERM_EN_POS = 2;

  typedef enum logic [2:0] {
    FRC_SRC_X = 3'b000,
    FRC_SRC_COMB = 3'b001,
    FRC_SRC_X_Y = 3'b010,
    FRC_SRC_X_COMB = 3'b011,
    FRC_SRC_Y_COMB = 3'b100
  } frc_src_t;

  typedef enum logic [1:0] {
    FRC_OP_ADD = 2'b00,
    FRC_OP_SUB = 2'b01,
    FRC_OP_MAX = 2'b10,
    FRC_OP_MIN = 2'b11
  } frc_op_t;

  typedef enum logic [1:0] {
    FRC_MODE_2W1 = 2'b00,
    FRC_MODE_2W2 = 2'b01,
    FRC_MODE_3W1 = 2'b10,
    FRC_MODE_3W2 = 2'b11
  } frc_mode_t;
endpackage

// *** src/frc_top.sv ***
// Frequency reference combiner and terminal run command decoder.
// Assumes inputs synchronous to clk_i; frequencies are signed fixed units.
// Notes on behaviour
// - Range base 0 scales auxiliary to max frequency; 1 to main reference.
// - Auxiliary range percent 0 to 150, default 0, scales auxiliary span.
// - With main as base, auxiliary span follows main reference continuously.
// - Source digit 0 takes main source X alone.
// - Source digit 1 takes the X and Y combination result.
// - Source digit 2 takes X, or Y while switchover terminal active.
// - Source digit 3 takes X, or combination while switchover active.
// - Source digit 4 takes Y, or combination while switchover active.
// - Operation 0 gives X plus Y.
// - Operation 1 gives X minus Y.
// - Operation 2 gives whichever of X, Y has larger magnitude.
// - Operation 3 gives whichever of X, Y has smaller magnitude.
// - Combined references get an added offset frequency.
// - Command mode 0..3: two-wire 1, two-wire 2, three-wire 1, 2.
// - Two-wire 1: forward alone runs forward, reverse alone reverse.
// - Two-wire 2: first input enables run, second picks direction.
// - Three-wire 1: button edge starts its direction while enabled.
// - Three-wire running state follows latest button and enable actions.
// - Polarity mask inverts selected terminals' active level.
// - Three-wire 2: edge on first starts, second picks direction.
// - Full-scale auxiliary input maps onto the configured auxiliary span.
`timescale 1ns/1ps
`default_nettype none
module frc_top #(
  parameter int FW = frc_pkg::FREQ_W,
  parameter int TN = frc_pkg::TERM_N
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic signed [FW-1:0] main_freq_i,
  input wire logic signed [FW-1:0] aux_input_i,
  input wire logic [FW-1:0] max_output_frequency_i,
  input wire logic signed [FW-1:0] combine_offset_frequency_i,
  input wire logic aux_range_base_select_i,
  input wire logic [frc_pkg::PCT_W-1:0] aux_range_percent_i,
  input wire logic [2:0] freq_source_combine_select_i,
  input wire logic [1:0] freq_operation_select_i,
  input wire logic freq_switchover_i,
  input wire logic [1:0] terminal_command_mode_i,
  input wire logic [TN-1:0] input_polarity_mask_i,
  input wire logic [TN-1:0] input_terminal_i,
  output logic signed [FW-1:0] target_freq_o,
  output logic run_forward_cmd_o,
  output logic run_reverse_cmd_o,
  output logic running_o
);
  import frc_pkg::*;

  typedef struct packed {
    logic signed [FW-1:0] target;
    logic run_forward_cmd;
    logic run_reverse_cmd;
    logic run;
    logic run3;
    logic dir3;
    logic [TN-1:0] term_prev;
    logic [PCT_W-1:0] pct;
  } frc_state_t;

  frc_state_t st;
  frc_state_t next_st;

  //////////////////////////////////////////////////////////////////////
  // Frequency path, combinational
  localparam int WW = FW + PCT_W + 2;
  // Span times a full-scale input needs more than WW bits
  localparam int PW = WW + FW;
  localparam int FULL_SCALE = (1 << (FW - 1)) - 1;

  logic signed [PW-1:0] prod_w;

  logic signed [WW-1:0] base_w;
  logic signed [WW-1:0] span_w;
  logic signed [WW-1:0] aux_w;
  logic signed [WW-1:0] x_w;
  logic signed [WW-1:0] comb_w;
  logic signed [WW-1:0] sel_w;
  logic signed [WW-1:0] lim_w;
  logic signed [WW-1:0] abs_x;
  logic signed [WW-1:0] abs_y;
  logic use_comb;
  logic use_y;
  logic [TN-1:0] term;
  logic [TN-1:0] rise;

  // Percent register clamped, so an out-of-range setting cannot overflow
  logic [PCT_W-1:0] pct_clamped;
  always_comb begin
    pct_clamped = (aux_range_percent_i > PCT_MAX) ? PCT_MAX
                                                  : aux_range_percent_i;
  end

  always_comb begin
    x_w = WW'(main_freq_i);
    // Main base is live every cycle, so span tracks X with no lag
    if (aux_range_base_select_i) begin
      base_w = x_w;
    end else begin
      base_w = WW'($signed({1'b0, max_output_frequency_i}));
    end
    span_w = WW'((base_w * $signed({1'b0, st.pct})) /
                 $signed({1'b0, PCT_FULL}));
    // Full-scale aux input equals FW-1 bit maximum
    prod_w = PW'(span_w) * PW'(aux_input_i);
    aux_w = WW'(prod_w / PW'(FULL_SCALE));
    abs_x = x_w[WW-1] ? -x_w : x_w;
    abs_y = aux_w[WW-1] ? -aux_w : aux_w;
    unique case (frc_op_t'(freq_operation_select_i))
      FRC_OP_ADD: comb_w = x_w + aux_w;
      FRC_OP_SUB: comb_w = x_w - aux_w;
      FRC_OP_MAX: comb_w = (abs_x >= abs_y) ? x_w : aux_w;
      FRC_OP_MIN: comb_w = (abs_x <= abs_y) ? x_w : aux_w;
    endcase
    comb_w = comb_w + WW'(combine_offset_frequency_i);
    use_comb = 1'b0;
    use_y = 1'b0;
    case (freq_source_combine_select_i)
      FRC_SRC_X: use_comb = 1'b0;
      FRC_SRC_COMB: use_comb = 1'b1;
      FRC_SRC_X_Y: use_y = freq_switchover_i;
      FRC_SRC_X_COMB: use_comb = freq_switchover_i;
      FRC_SRC_Y_COMB: begin
        use_comb = freq_switchover_i;
        use_y = !freq_switchover_i;
      end
      // Illegal digits fall back to main source alone
      default: use_comb = 1'b0;
    endcase
    sel_w = use_comb ? comb_w : (use_y ? aux_w : x_w);
    lim_w = WW'($signed({1'b0, max_output_frequency_i}));
    // Cap to what the signed target port can carry
    if (lim_w > WW'(FULL_SCALE)) begin
      lim_w = WW'(FULL_SCALE);
    end
    if (sel_w > lim_w) begin
      sel_w = lim_w;
    end else if (sel_w < -lim_w) begin
      sel_w = -lim_w;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Terminal polarity and edges
  genvar gi;
  generate
    for (gi = 0; gi < TN; gi++) begin : g_term
      assign term[gi] = input_terminal_i[gi] ^ input_polarity_mask_i[gi];
      assign rise[gi] = term[gi] & ~st.term_prev[gi];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st = st;
    next_st.pct = pct_clamped;
    next_st.target = FW'(sel_w);
    next_st.term_prev = term;
    unique case (frc_mode_t'(terminal_command_mode_i))
      FRC_MODE_2W1: begin
        next_st.run_forward_cmd = term[TERM_FWD_POS] & ~term[TERM_REV_POS];
        next_st.run_reverse_cmd = term[TERM_REV_POS] & ~term[TERM_FWD_POS];
        next_st.run3 = 1'b0;
      end
      FRC_MODE_2W2: begin
        next_st.run_forward_cmd = term[TERM_FWD_POS] & ~term[TERM_REV_POS];
        next_st.run_reverse_cmd = term[TERM_FWD_POS] & term[TERM_REV_POS];
        next_st.run3 = 1'b0;
      end
      FRC_MODE_3W1: begin
        // Latest button edge wins; both at once keeps previous direction
        if (!term[TERM_EN_POS]) begin
          next_st.run3 = 1'b0;
        end else if (rise[TERM_FWD_POS] && !rise[TERM_REV_POS]) begin
          next_st.run3 = 1'b1;
          next_st.dir3 = 1'b0;
        end else if (rise[TERM_REV_POS] && !rise[TERM_FWD_POS]) begin
          next_st.run3 = 1'b1;
          next_st.dir3 = 1'b1;
        end
        next_st.run_forward_cmd = next_st.run3 & ~next_st.dir3;
        next_st.run_reverse_cmd = next_st.run3 & next_st.dir3;
      end
      FRC_MODE_3W2: begin
        if (!term[TERM_EN_POS]) begin
          next_st.run3 = 1'b0;
        end else if (rise[TERM_FWD_POS]) begin
          next_st.run3 = 1'b1;
        end
        next_st.dir3 = term[TERM_REV_POS];
        next_st.run_forward_cmd = next_st.run3 & ~next_st.dir3;
        next_st.run_reverse_cmd = next_st.run3 & next_st.dir3;
      end
    endcase
    // Registered so running_o comes straight from a flop
    next_st.run = next_st.run_forward_cmd | next_st.run_reverse_cmd;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st.target <= '0;
      st.run_forward_cmd <= 1'b0;
      st.run_reverse_cmd <= 1'b0;
      st.run <= 1'b0;
      st.run3 <= 1'b0;
      st.dir3 <= 1'b0;
      // All-ones avoids a false start edge from held buttons at release
      st.term_prev <= '1;
      st.pct <= PCT_RESET;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs
  assign target_freq_o = st.target;
  assign run_forward_cmd_o = st.run_forward_cmd;
  assign run_reverse_cmd_o = st.run_reverse_cmd;
  assign running_o = st.run;
endmodule
`default_nettype wire

// *** verification/frc_contacts.sv ***
// Switch and push button model on the terminal side of frc_top.
// Assumes contacts settle between clocks; no bounce is modelled.
`timescale 1ns/1ps
`default_nettype none
module frc_contacts (
  input wire logic clk_i,
  input wire logic [4:0] press_i,
  output logic [4:0] term_o
);
  // Contacts move on the falling edge, away from the sampling edge
  always @(negedge clk_i) begin
    term_o <= press_i;
  end
endmodule
`default_nettype wire

// *** verification/frc_checker.sv ***
// Port checker for frc_top, attached by bind.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module frc_checker #(
  parameter int FW = 16,
  parameter int TN = 5
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic signed [FW-1:0] main_freq_i,
  input wire logic [FW-1:0] max_output_frequency_i,
  input wire logic [2:0] freq_source_combine_select_i,
  input wire logic freq_switchover_i,
  input wire logic [1:0] terminal_command_mode_i,
  input wire logic [TN-1:0] input_polarity_mask_i,
  input wire logic [TN-1:0] input_terminal_i,
  input wire logic signed [FW-1:0] target_freq_o,
  input wire logic run_forward_cmd_o,
  input wire logic run_reverse_cmd_o,
  input wire logic running_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [TN-1:0] t;
  logic [TN-1:0] pt;
  logic [1:0] m;
  logic [2:0] s;
  logic xin;
  assign t = input_terminal_i ^ input_polarity_mask_i;
  assign m = terminal_command_mode_i;
  assign s = freq_source_combine_select_i;
  assign xin = !main_freq_i[FW-1] &&
    $unsigned(main_freq_i) <= max_output_frequency_i;
  always_ff @(posedge clk_i) pt <= t;
  property p_excl; !(run_forward_cmd_o && run_reverse_cmd_o); endproperty
  a_excl: assert property (p_excl) else $error("both directions");
  property p_2w1; m == 2'h0 |=> run_forward_cmd_o == (pt[0] && !pt[1])
    && run_reverse_cmd_o == (pt[1] && !pt[0]); endproperty
  a_2w1: assert property (p_2w1) else $error("two-wire 1 run");
  property p_2w2; m == 2'h1 |=> run_forward_cmd_o == (pt[0] && !pt[1])
    && run_reverse_cmd_o == (pt[0] && pt[1]); endproperty
  a_2w2: assert property (p_2w2) else $error("two-wire 2 run");
  property p_stop; m[1] && !t[2] |=> !running_o; endproperty
  a_stop: assert property (p_stop) else $error("no stop on enable");
  property p_idle; m[1] && !running_o && !(t[0] && !pt[0])
    && !(t[1] && !pt[1]) |=> !running_o; endproperty
  a_idle: assert property (p_idle) else $error("start without edge");
  property p_dir; m == 2'h3 && t[2] && running_o
    |=> running_o && run_reverse_cmd_o == pt[1]; endproperty
  a_dir: assert property (p_dir) else $error("direction level");
  property p_xsel; (s == 3'h0 || ((s == 3'h2 || s == 3'h3) &&
    !freq_switchover_i)) && xin |=> target_freq_o == $past(main_freq_i);
  endproperty
  a_xsel: assert property (p_xsel) else $error("main not taken");
  property p_clamp; 1'b1 |=> $unsigned(target_freq_o[FW-1] ? -target_freq_o
    : target_freq_o) <= $past(max_output_frequency_i); endproperty
  a_clamp: assert property (p_clamp) else $error("target over max");
endmodule
bind frc_top frc_checker #(.FW(FW), .TN(TN)) frc_checker_inst (.clk_i,
  .rst_b_i, .main_freq_i, .max_output_frequency_i,
  .freq_source_combine_select_i, .freq_switchover_i,
  .terminal_command_mode_i, .input_polarity_mask_i, .input_terminal_i,
  .target_freq_o, .run_forward_cmd_o, .run_reverse_cmd_o, .running_o);
`default_nettype wire

// *** verification/frc_top_test.sv ***
// Bench for frc_top: target selection and terminal run commands.
// Assumes frc_contacts stands for the switches and buttons.
`timescale 1ns/1ps
`default_nettype none
module frc_top_test;
  import frc_pkg::*;
  logic clk_i = 0, rst_b_i = 0, base = 0, swo = 0, run_forward_cmd, run_reverse_cmd, run;
  logic signed [15:0] x = 0, aux = 16'h7FFF, ofs = 16'h0007, tgt;
  logic [15:0] mx = 16'h03E8;
  logic [7:0] pct = 8'h32;
  logic [2:0] src = 0;
  logic [1:0] op = 0, mode = 0;
  logic [4:0] pol = 0, press = 0, term;
  int num_errors = 0, checked = 0;
  always #25 clk_i = ~clk_i;
  // Main and auxiliary come from separate ports, never one channel
  frc_top frc_top_inst (.clk_i, .rst_b_i, .main_freq_i(x),
    .aux_input_i(aux), .max_output_frequency_i(mx),
    .combine_offset_frequency_i(ofs), .aux_range_base_select_i(base),
    .aux_range_percent_i(pct), .freq_source_combine_select_i(src),
    .freq_operation_select_i(op), .freq_switchover_i(swo),
    .terminal_command_mode_i(mode), .input_polarity_mask_i(pol),
    .input_terminal_i(term), .target_freq_o(tgt),
    .run_forward_cmd_o(run_forward_cmd), .run_reverse_cmd_o(run_reverse_cmd), .running_o(run));
  frc_contacts frc_contacts_inst (.clk_i, .press_i(press), .term_o(term));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // Three cycles cover the registered percent path plus the target register
  task automatic ft(input logic [2:0] s, input logic [1:0] o,
      input logic w, input logic [15:0] xv, input logic [15:0] exp);
    @(negedge clk_i);
    src = s;
    op = o;
    swo = w;
    x = xv;
    repeat (3) @(posedge clk_i);
    #1 chk(tgt, exp);
  endtask
  task automatic tc(input logic [4:0] p, input logic [2:0] e);
    @(negedge clk_i);
    press = p;
    repeat (3) @(posedge clk_i);
    #1 chk({13'h0000, run_forward_cmd, run_reverse_cmd, run}, {13'h0000, e});
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    @(negedge clk_i) rst_b_i = 1;
    tc(5'h00, 3'h0);
    ft(3'h1, 2'h0, 1'b0, 16'h012C, 16'h0327);
    ft(3'h1, 2'h1, 1'b0, 16'h012C, 16'hFF3F);
    ft(3'h1, 2'h2, 1'b0, 16'h012C, 16'h01FB);
    ft(3'h1, 2'h3, 1'b0, 16'h012C, 16'h0133);
    ft(3'h0, 2'h0, 1'b1, 16'h012C, 16'h012C);
    ft(3'h2, 2'h0, 1'b0, 16'h012C, 16'h012C);
    ft(3'h2, 2'h0, 1'b1, 16'h012C, 16'h01F4);
    ft(3'h3, 2'h0, 1'b0, 16'h012C, 16'h012C);
    ft(3'h3, 2'h0, 1'b1, 16'h012C, 16'h0327);
    ft(3'h4, 2'h0, 1'b0, 16'h012C, 16'h01F4);
    ft(3'h4, 2'h0, 1'b1, 16'h012C, 16'h0327);
    ft(3'h0, 2'h0, 1'b0, 16'h07D0, 16'h03E8);
    ft(3'h0, 2'h0, 1'b0, 16'hF830, 16'hFC18);
    @(negedge clk_i) {aux, pct} = {16'h3FFF, 8'h64};
    ft(3'h2, 2'h0, 1'b1, 16'h012C, 16'h01F3);
    @(negedge clk_i) {aux, base} = {16'h7FFF, 1'b1};
    ft(3'h2, 2'h0, 1'b1, 16'h012C, 16'h012C);
    ft(3'h2, 2'h0, 1'b1, 16'h0190, 16'h0190);
    @(negedge clk_i) pct = 8'h96;
    ft(3'h2, 2'h0, 1'b1, 16'h00C8, 16'h012C);
    @(negedge clk_i) pct = 8'hC8;
    ft(3'h2, 2'h0, 1'b1, 16'h00C8, 16'h012C);
    tc(5'h01, 3'h5); tc(5'h03, 3'h0); tc(5'h02, 3'h3);
    @(negedge clk_i) mode = 2'h1;
    tc(5'h01, 3'h5); tc(5'h03, 3'h3); tc(5'h02, 3'h0);
    @(negedge clk_i) mode = 2'h2;
    tc(5'h04, 3'h0); tc(5'h05, 3'h5); tc(5'h04, 3'h5);
    tc(5'h06, 3'h3); tc(5'h02, 3'h0); tc(5'h06, 3'h0);
    @(negedge clk_i) mode = 2'h3;
    tc(5'h04, 3'h0); tc(5'h05, 3'h5); tc(5'h07, 3'h3);
    tc(5'h06, 3'h3); tc(5'h03, 3'h0);
    @(negedge clk_i) {mode, pol} = {2'h2, 5'h04};
    tc(5'h00, 3'h0); tc(5'h01, 3'h5); tc(5'h05, 3'h0);
    close_out();
  end
endmodule
`default_nettype wire
